// ==== src/emcr_pkg.sv ====
// Constants and types for the metering calibration register bank
package emcr_pkg;

  // Core-side special function register addresses
  localparam logic [7:0] SFR_POINTER   = 8'h91;
  localparam logic [7:0] SFR_DATA_LOW  = 8'h92;
  localparam logic [7:0] SFR_DATA_MID  = 8'h93;
  localparam logic [7:0] SFR_DATA_HIGH = 8'h94;
  localparam int         PTR_WRITE_BIT = 7;

  // Internal register offsets
  localparam logic [6:0] OFS_NO_LOAD   = 7'h0e;
  localparam logic [6:0] OFS_ACCUM     = 7'h0f;
  localparam logic [6:0] OFS_PHASE     = 7'h10;
  localparam logic [6:0] OFS_ZX_TOUT   = 7'h11;
  localparam logic [6:0] OFS_LINE_CYC  = 7'h12;
  localparam logic [6:0] OFS_SAG_CYC   = 7'h13;
  localparam logic [6:0] OFS_SAG_LVL   = 7'h14;
  localparam logic [6:0] OFS_I_PK_LVL  = 7'h15;
  localparam logic [6:0] OFS_V_PK_LVL  = 7'h16;
  localparam logic [6:0] OFS_I_PEAK    = 7'h17;
  localparam logic [6:0] OFS_I_PEAK_RC = 7'h18;
  localparam logic [6:0] OFS_V_PEAK    = 7'h19;
  localparam logic [6:0] OFS_V_PEAK_RC = 7'h1a;
  localparam logic [6:0] OFS_AMP_GAIN  = 7'h1b;
  localparam logic [6:0] OFS_I2_GAIN   = 7'h1c;
  localparam logic [6:0] OFS_W_GAIN    = 7'h1d;
  localparam logic [6:0] OFS_VAR_GAIN  = 7'h1e;
  localparam logic [6:0] OFS_VA_GAIN   = 7'h1f;
  localparam logic [6:0] OFS_W_OFS     = 7'h20;
  localparam logic [6:0] OFS_VAR_OFS   = 7'h21;
  localparam logic [6:0] OFS_IRMS_OFS  = 7'h22;
  localparam logic [6:0] OFS_VRMS_OFS  = 7'h23;
  localparam logic [6:0] OFS_W_DIV     = 7'h24;
  localparam logic [6:0] OFS_VAR_DIV   = 7'h25;
  localparam logic [6:0] OFS_VA_DIV    = 7'h26;
  localparam logic [6:0] OFS_PO1_NUM   = 7'h27;
  localparam logic [6:0] OFS_PO1_DEN   = 7'h28;

  // Values after reset
  localparam logic [7:0]  RST_ZERO8    = 8'h00;
  localparam logic [11:0] RST_ZERO12   = 12'h000;
  localparam logic [15:0] RST_ZERO16   = 16'h0000;
  localparam logic [23:0] RST_PEAK     = 24'h000000;
  localparam logic [7:0]  RST_PHASE    = 8'h40;
  localparam logic [11:0] RST_ZX_TOUT  = 12'hfff;
  localparam logic [15:0] RST_LINE_CYC = 16'hffff;
  localparam logic [7:0]  RST_SAG_CYC  = 8'hff;
  localparam logic [15:0] RST_PK_LVL   = 16'hffff;
  localparam logic [15:0] RST_PO1_DEN  = 16'h003f;

  // Settling time after an internal write: metering clock 819.2 kHz, in tenths of Hz
  localparam longint CORE_CLK_HZ       = 100_000_000;
  localparam longint METER_CLK_DHZ     = 8_192_000;
  localparam longint SETTLE_PERIODS    = 2;
  localparam longint SETTLE_CYC_L      =
    (SETTLE_PERIODS * CORE_CLK_HZ * 10 + METER_CLK_DHZ - 1) / METER_CLK_DHZ;
  localparam logic [8:0] SETTLE_CYC    = 9'(SETTLE_CYC_L);

  typedef struct packed {
    logic [7:0]  no_load_threshold_mode;
    logic [7:0]  accumulation_config;
    logic [7:0]  phase_compensation;
    logic [11:0] zero_cross_timeout;
    logic [15:0] line_cycle_count;
    logic [7:0]  sag_half_cycles;
    logic [15:0] sag_threshold;
    logic [15:0] current_peak_threshold;
    logic [15:0] voltage_peak_threshold;
    logic [7:0]  input_amp_gain;
    logic [11:0] second_current_match_gain;
    logic [11:0] active_power_gain;
    logic [11:0] reactive_power_gain;
    logic [11:0] apparent_power_gain;
    logic [15:0] active_power_offset;
    logic [15:0] reactive_power_offset;
    logic [11:0] current_rms_offset;
    logic [11:0] voltage_rms_offset;
    logic [7:0]  active_energy_divider;
    logic [7:0]  reactive_energy_divider;
    logic [7:0]  apparent_energy_divider;
    logic [15:0] pulse_out_one_numerator;
    logic [15:0] pulse_out_one_denominator;
  } emcr_cfg_s;

  localparam emcr_cfg_s CFG_RESET = '{
    no_load_threshold_mode:    RST_ZERO8,
    accumulation_config:       RST_ZERO8,
    phase_compensation:        RST_PHASE,
    zero_cross_timeout:        RST_ZX_TOUT,
    line_cycle_count:          RST_LINE_CYC,
    sag_half_cycles:           RST_SAG_CYC,
    sag_threshold:             RST_ZERO16,
    current_peak_threshold:    RST_PK_LVL,
    voltage_peak_threshold:    RST_PK_LVL,
    input_amp_gain:            RST_ZERO8,
    second_current_match_gain: RST_ZERO12,
    active_power_gain:         RST_ZERO12,
    reactive_power_gain:       RST_ZERO12,
    apparent_power_gain:       RST_ZERO12,
    active_power_offset:       RST_ZERO16,
    reactive_power_offset:     RST_ZERO16,
    current_rms_offset:        RST_ZERO12,
    voltage_rms_offset:        RST_ZERO12,
    active_energy_divider:     RST_ZERO8,
    reactive_energy_divider:   RST_ZERO8,
    apparent_energy_divider:   RST_ZERO8,
    pulse_out_one_numerator:   RST_ZERO16,
    pulse_out_one_denominator: RST_PO1_DEN
  };

endpackage

// ==== src/emcr_bank.sv ====
// Indirectly addressed metering calibration register bank
// Notes on behaviour
// RL1: Pointer write, top bit clear, loads data bytes
// RL2: One-byte register read zeroes middle and high bytes
// RL3: Busy flag marks a settle time after each internal write; the core waits only when asked
// RL4: Pointer write, top bit set, stores data bytes
// RL5: No-load mode: 8 bits, read-write, reset zero
// RL6: Accumulation config: 8 bits, read-write, reset zero
// RL7: Phase compensation: 8 bits signed, reset 0x40
// RL8: Zero-cross timeout: 12 bits, reset all ones
// RL9: Line cycle count: 16 bits, reset 0xffff
// RL10: Sag half cycles: 8 bits, reset 0xff
// RL11: Sag threshold: 16 bits, reset zero
// RL12: Peak thresholds: 16 bits each, reset 0xffff
// RL13: Current peak alias reads without clearing
// RL14: Current peak clearing alias reads, then zeroes
// RL15: Voltage peak alias reads without clearing
// RL16: Voltage peak clearing alias reads, then zeroes
// RL17: Amplifier gain: 8 bits, read-write, reset zero
// RL18: Second current match gain: 12 bits signed
// RL19: Three power gains: 12 bits signed, zero
// RL20: Two power offsets: 16 bits signed, zero
// RL21: Two rms offsets: 12 bits signed, zero
// RL22: Three energy dividers: 8 bits, zero
// RL23: Pulse output numerator: 16 bits, zero
// RL24: Pulse output denominator: 16 bits, 0x003f
`timescale 1ns/1ps
`default_nettype none

module emcr_bank
  import emcr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Core special function register port
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  // Peak samples from the metering datapath
  input  wire logic        cur_sample_valid,
  input  wire logic [23:0] cur_sample,
  input  wire logic        volt_sample_valid,
  input  wire logic [23:0] volt_sample,
  // Configuration to the metering datapath
  output var  emcr_cfg_s   cfg,
  output var  logic [23:0] current_peak,
  output var  logic [23:0] voltage_peak,
  output var  logic        write_settle_busy
);

  logic [7:0]  pointer;
  logic [7:0]  data_low;
  logic [7:0]  data_mid;
  logic [7:0]  data_high;
  logic [8:0]  settle_cnt;
  logic        ptr_wr;
  logic        int_read;
  logic        int_write;
  logic [6:0]  int_addr;
  logic [23:0] wr_word;
  logic [23:0] rd_value;
  logic        rd_one_byte;
  logic        clr_cur;
  logic        clr_volt;

  assign ptr_wr    = sfr_wr && (sfr_addr == SFR_POINTER);
  assign int_read  = ptr_wr && !sfr_wdata[PTR_WRITE_BIT];
  assign int_write = ptr_wr && sfr_wdata[PTR_WRITE_BIT];
  assign int_addr  = sfr_wdata[6:0];
  assign wr_word   = {data_high, data_mid, data_low};
  assign clr_cur   = int_read && (int_addr == OFS_I_PEAK_RC);
  assign clr_volt  = int_read && (int_addr == OFS_V_PEAK_RC);

  // Read mux; unmapped offsets read as zero, narrow values zero-padded
  always_comb begin
    rd_value    = 24'h000000;
    rd_one_byte = 1'b0;
    case (int_addr)
      OFS_NO_LOAD:   begin
        rd_value    = {16'h0000, cfg.no_load_threshold_mode};
        rd_one_byte = 1'b1;
      end
      OFS_ACCUM:     begin
        rd_value    = {16'h0000, cfg.accumulation_config};
        rd_one_byte = 1'b1;
      end
      OFS_PHASE:     begin
        rd_value    = {16'h0000, cfg.phase_compensation};
        rd_one_byte = 1'b1;
      end
      OFS_ZX_TOUT:   rd_value = {12'h000, cfg.zero_cross_timeout};
      OFS_LINE_CYC:  rd_value = {8'h00, cfg.line_cycle_count};
      OFS_SAG_CYC:   begin
        rd_value    = {16'h0000, cfg.sag_half_cycles};
        rd_one_byte = 1'b1;
      end
      OFS_SAG_LVL:   rd_value = {8'h00, cfg.sag_threshold};
      OFS_I_PK_LVL:  rd_value = {8'h00, cfg.current_peak_threshold};
      OFS_V_PK_LVL:  rd_value = {8'h00, cfg.voltage_peak_threshold};
      OFS_I_PEAK,
      OFS_I_PEAK_RC: rd_value = current_peak;
      OFS_V_PEAK,
      OFS_V_PEAK_RC: rd_value = voltage_peak;
      OFS_AMP_GAIN:  begin
        rd_value    = {16'h0000, cfg.input_amp_gain};
        rd_one_byte = 1'b1;
      end
      OFS_I2_GAIN:   rd_value = {12'h000, cfg.second_current_match_gain};
      OFS_W_GAIN:    rd_value = {12'h000, cfg.active_power_gain};
      OFS_VAR_GAIN:  rd_value = {12'h000, cfg.reactive_power_gain};
      OFS_VA_GAIN:   rd_value = {12'h000, cfg.apparent_power_gain};
      OFS_W_OFS:     rd_value = {8'h00, cfg.active_power_offset};
      OFS_VAR_OFS:   rd_value = {8'h00, cfg.reactive_power_offset};
      OFS_IRMS_OFS:  rd_value = {12'h000, cfg.current_rms_offset};
      OFS_VRMS_OFS:  rd_value = {12'h000, cfg.voltage_rms_offset};
      OFS_W_DIV:     begin
        rd_value    = {16'h0000, cfg.active_energy_divider};
        rd_one_byte = 1'b1;
      end
      OFS_VAR_DIV:   begin
        rd_value    = {16'h0000, cfg.reactive_energy_divider};
        rd_one_byte = 1'b1;
      end
      OFS_VA_DIV:    begin
        rd_value    = {16'h0000, cfg.apparent_energy_divider};
        rd_one_byte = 1'b1;
      end
      OFS_PO1_NUM:   rd_value = {8'h00, cfg.pulse_out_one_numerator};
      OFS_PO1_DEN:   rd_value = {8'h00, cfg.pulse_out_one_denominator};
      default:       rd_value = 24'h000000;
    endcase
  end

  // Pointer and data bytes; an internal read overwrites core-written data
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pointer   <= 8'h00;
      data_low  <= 8'h00;
      data_mid  <= 8'h00;
      data_high <= 8'h00;
    end else if (int_read) begin
      pointer   <= sfr_wdata;
      data_low  <= rd_value[7:0];                            // [RL1]
      data_mid  <= rd_one_byte ? 8'h00 : rd_value[15:8];     // [RL2]
      data_high <= rd_one_byte ? 8'h00 : rd_value[23:16];    // [RL2]
    end else if (sfr_wr) begin
      case (sfr_addr)
        SFR_POINTER:   pointer   <= sfr_wdata;
        SFR_DATA_LOW:  data_low  <= sfr_wdata;
        SFR_DATA_MID:  data_mid  <= sfr_wdata;
        SFR_DATA_HIGH: data_high <= sfr_wdata;
        default:       pointer   <= pointer;
      endcase
    end
  end

  // Core readback, one cycle after the read strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        SFR_POINTER:   sfr_rdata <= pointer;
        SFR_DATA_LOW:  sfr_rdata <= data_low;
        SFR_DATA_MID:  sfr_rdata <= data_mid;
        SFR_DATA_HIGH: sfr_rdata <= data_high;
        default:       sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Internal writes; peak aliases and unmapped offsets ignore them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_RESET;                                      // [RL5] [RL6] [RL7] [RL24]
    end else if (int_write) begin                            // [RL4]
      case (int_addr)
        OFS_NO_LOAD:  cfg.no_load_threshold_mode    <= wr_word[7:0];   // [RL5]
        OFS_ACCUM:    cfg.accumulation_config       <= wr_word[7:0];   // [RL6]
        OFS_PHASE:    cfg.phase_compensation        <= wr_word[7:0];   // [RL7]
        OFS_ZX_TOUT:  cfg.zero_cross_timeout        <= wr_word[11:0];  // [RL8]
        OFS_LINE_CYC: cfg.line_cycle_count          <= wr_word[15:0];  // [RL9]
        OFS_SAG_CYC:  cfg.sag_half_cycles           <= wr_word[7:0];   // [RL10]
        OFS_SAG_LVL:  cfg.sag_threshold             <= wr_word[15:0];  // [RL11]
        OFS_I_PK_LVL: cfg.current_peak_threshold    <= wr_word[15:0];  // [RL12]
        OFS_V_PK_LVL: cfg.voltage_peak_threshold    <= wr_word[15:0];  // [RL12]
        OFS_AMP_GAIN: cfg.input_amp_gain            <= wr_word[7:0];   // [RL17]
        OFS_I2_GAIN:  cfg.second_current_match_gain <= wr_word[11:0];  // [RL18]
        OFS_W_GAIN:   cfg.active_power_gain         <= wr_word[11:0];  // [RL19]
        OFS_VAR_GAIN: cfg.reactive_power_gain       <= wr_word[11:0];  // [RL19]
        OFS_VA_GAIN:  cfg.apparent_power_gain       <= wr_word[11:0];  // [RL19]
        OFS_W_OFS:    cfg.active_power_offset       <= wr_word[15:0];  // [RL20]
        OFS_VAR_OFS:  cfg.reactive_power_offset     <= wr_word[15:0];  // [RL20]
        OFS_IRMS_OFS: cfg.current_rms_offset        <= wr_word[11:0];  // [RL21]
        OFS_VRMS_OFS: cfg.voltage_rms_offset        <= wr_word[11:0];  // [RL21]
        OFS_W_DIV:    cfg.active_energy_divider     <= wr_word[7:0];   // [RL22]
        OFS_VAR_DIV:  cfg.reactive_energy_divider   <= wr_word[7:0];   // [RL22]
        OFS_VA_DIV:   cfg.apparent_energy_divider   <= wr_word[7:0];   // [RL22]
        OFS_PO1_NUM:  cfg.pulse_out_one_numerator   <= wr_word[15:0];  // [RL23]
        OFS_PO1_DEN:  cfg.pulse_out_one_denominator <= wr_word[15:0];  // [RL24]
        default:      cfg <= cfg;
      endcase
    end
  end

  // Peak capture; a sample arriving with a clearing read survives it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      current_peak <= RST_PEAK;
    end else if (clr_cur) begin
      current_peak <= cur_sample_valid ? cur_sample : RST_PEAK;          // [RL14]
    end else if (cur_sample_valid && (cur_sample > current_peak)) begin  // [RL13]
      current_peak <= cur_sample;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      voltage_peak <= RST_PEAK;
    end else if (clr_volt) begin
      voltage_peak <= volt_sample_valid ? volt_sample : RST_PEAK;          // [RL16]
    end else if (volt_sample_valid && (volt_sample > voltage_peak)) begin  // [RL15]
      voltage_peak <= volt_sample;
    end
  end

  // Busy flag models the metering clock crossing; it does not block the core
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt        <= 9'h000;
      write_settle_busy <= 1'b0;
    end else if (int_write) begin
      settle_cnt        <= SETTLE_CYC;                       // [RL3]
      write_settle_busy <= 1'b1;
    end else if (settle_cnt != 9'h000) begin
      settle_cnt        <= settle_cnt - 9'h001;
      write_settle_busy <= (settle_cnt != 9'h001);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence rd_cmd_s;
    int_read && !rd_one_byte;
  endsequence

  sequence wr_cmd_s;
    int_write;
  endsequence

  read_load_a: assert property (rd_cmd_s |=> wr_word == $past(rd_value)) // [RL1]
    else $error("data bytes not loaded from internal register");

  byte_zero_a: assert property (int_read && rd_one_byte |=>            // [RL2]
    data_mid == 8'h00 && data_high == 8'h00 && data_low == $past(rd_value[7:0]))
    else $error("one-byte read left upper data bytes nonzero");

  busy_span_a: assert property (wr_cmd_s |=> write_settle_busy [*8])   // [RL3]
    else $error("settle flag dropped too early");

  sag_store_a: assert property (wr_cmd_s ##0 (int_addr == OFS_SAG_LVL)  // [RL4]
    |=> cfg.sag_threshold == $past(wr_word[15:0]))
    else $error("sag threshold not stored from data bytes");

  phase_hold_a: assert property ($changed(cfg.phase_compensation)     // [RL7]
    |-> $past(int_write && int_addr == OFS_PHASE))
    else $error("phase compensation changed without a write");

  ipk_keep_a: assert property (int_read && int_addr == OFS_I_PEAK     // [RL13]
    && !cur_sample_valid |=> $stable(current_peak))
    else $error("current peak changed by non-clearing read");

  ipk_clear_a: assert property (clr_cur && !cur_sample_valid           // [RL14]
    |=> current_peak == 24'h000000 && wr_word == $past(current_peak))
    else $error("current peak not returned then cleared");

  vpk_clear_a: assert property (clr_volt && !volt_sample_valid         // [RL16]
    |=> voltage_peak == 24'h000000 && wr_word == $past(voltage_peak))
    else $error("voltage peak not returned then cleared");

  vpk_keep_a: assert property (int_read && int_addr == OFS_V_PEAK      // [RL15]
    && !volt_sample_valid |=> $stable(voltage_peak))
    else $error("voltage peak changed by non-clearing read");

  sequence cur_rise_s;
    cur_sample_valid && !clr_cur && (cur_sample > current_peak);
  endsequence

  sequence volt_rise_s;
    volt_sample_valid && !clr_volt && (volt_sample > voltage_peak);
  endsequence

  sequence settle_last_s;
    !int_write && (settle_cnt == 9'h001);
  endsequence

  ipk_grow_a: assert property (cur_rise_s |=> current_peak == $past(cur_sample))  // [RL13]
    else $error("current peak missed a larger sample");

  vpk_grow_a: assert property (volt_rise_s |=> voltage_peak == $past(volt_sample))  // [RL15]
    else $error("voltage peak missed a larger sample");

  ipk_set_a: assert property (clr_cur && cur_sample_valid  // [RL14]
    |=> current_peak == $past(cur_sample))
    else $error("sample lost in current peak clear");

  vpk_set_a: assert property (clr_volt && volt_sample_valid  // [RL16]
    |=> voltage_peak == $past(volt_sample))
    else $error("sample lost in voltage peak clear");

  busy_end_a: assert property (settle_last_s |=> !write_settle_busy)  // [RL3]
    else $error("settle flag held past its count");

  busy_idle_a: assert property (!int_write && settle_cnt == 9'h000  // [RL3]
    |=> !write_settle_busy)
    else $error("settle flag raised without a write");

  ptr_load_a: assert property (sfr_wr && sfr_addr == SFR_POINTER  // [RL1]
    |=> pointer == $past(sfr_wdata))
    else $error("pointer byte not written");

  low_load_a: assert property (sfr_wr && sfr_addr == SFR_DATA_LOW  // [RL4]
    |=> data_low == $past(sfr_wdata))
    else $error("low data byte not written");

  mid_load_a: assert property (sfr_wr && sfr_addr == SFR_DATA_MID  // [RL4]
    |=> data_mid == $past(sfr_wdata))
    else $error("middle data byte not written");

  high_load_a: assert property (sfr_wr && sfr_addr == SFR_DATA_HIGH  // [RL4]
    |=> data_high == $past(sfr_wdata))
    else $error("high data byte not written");

  ptr_echo_a: assert property (sfr_rd && sfr_addr == SFR_POINTER  // [RL1]
    |=> sfr_rdata == $past(pointer))
    else $error("pointer readback wrong");

  low_echo_a: assert property (sfr_rd && sfr_addr == SFR_DATA_LOW  // [RL1]
    |=> sfr_rdata == $past(data_low))
    else $error("low data byte readback wrong");

  mid_echo_a: assert property (sfr_rd && sfr_addr == SFR_DATA_MID  // [RL1]
    |=> sfr_rdata == $past(data_mid))
    else $error("middle data byte readback wrong");

  high_echo_a: assert property (sfr_rd && sfr_addr == SFR_DATA_HIGH  // [RL1]
    |=> sfr_rdata == $past(data_high))
    else $error("high data byte readback wrong");

  cfg_quiet_a: assert property ($changed(cfg) |-> $past(int_write))  // [RL4]
    else $error("configuration changed without an internal write");

  alias_ro_a: assert property (int_write && int_addr >= OFS_I_PEAK  // [RL13]
    && int_addr <= OFS_V_PEAK_RC |=> $stable(cfg))
    else $error("peak alias write changed configuration");

  tout_store_a: assert property (int_write && int_addr == OFS_ZX_TOUT  // [RL8]
    |=> cfg.zero_cross_timeout == $past(wr_word[11:0]))
    else $error("timeout not stored from data bytes");

  line_store_a: assert property (int_write && int_addr == OFS_LINE_CYC  // [RL9]
    |=> cfg.line_cycle_count == $past(wr_word[15:0]))
    else $error("line cycle count not stored from data bytes");

  den_store_a: assert property (int_write && int_addr == OFS_PO1_DEN  // [RL24]
    |=> cfg.pulse_out_one_denominator == $past(wr_word[15:0]))
    else $error("denominator not stored from data bytes");

endmodule

`default_nettype wire

// ==== tb/emcr_core_model.sv ====
// Core-side model that drives the bank's special function register port
`timescale 1ns/1ps
`default_nettype none

module emcr_core_model
  import emcr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Register port
  output var  logic        sfr_wr,
  output var  logic        sfr_rd,
  output var  logic [7:0]  sfr_addr,
  output var  logic [7:0]  sfr_wdata,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic        write_settle_busy,
  // Raised when a settle wait runs out
  output var  logic        hang
);
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    hang = 1'b0;
  end

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    // Released bus shows junk, not the last value
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge core_clk);
    #1;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask

  // Slow metering domain needs time after each internal write
  task automatic wait_settle();
    int n;
    for (n = 0; n < 400 && write_settle_busy !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (write_settle_busy !== 1'b0) begin
      hang = 1'b1;
    end
  endtask

  task automatic reg_write(input logic [6:0] o, input logic [23:0] v, input bit settle);
    sfr_write(SFR_DATA_HIGH, v[23:16]);
    sfr_write(SFR_DATA_MID, v[15:8]);
    sfr_write(SFR_DATA_LOW, v[7:0]);
    sfr_write(SFR_POINTER, {1'b1, o});
    if (settle) begin
      wait_settle();
    end
  endtask

  task automatic reg_read(input logic [6:0] o, output logic [23:0] v);
    sfr_write(SFR_POINTER, {1'b0, o});
    sfr_read(SFR_DATA_LOW, v[7:0]);
    sfr_read(SFR_DATA_MID, v[15:8]);
    sfr_read(SFR_DATA_HIGH, v[23:16]);
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  import emcr_pkg::*;

  logic        core_clk;
  logic        nrst;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        cur_sample_valid;
  logic [23:0] cur_sample;
  logic        volt_sample_valid;
  logic [23:0] volt_sample;
  emcr_cfg_s   cfg;
  logic [23:0] current_peak;
  logic [23:0] voltage_peak;
  logic        write_settle_busy;
  logic        hang;
  int          mismatches;
  int          total_checks;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  emcr_bank DUT (
    .core_clk(core_clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cur_sample_valid(cur_sample_valid), .cur_sample(cur_sample),
    .volt_sample_valid(volt_sample_valid), .volt_sample(volt_sample),
    .cfg(cfg), .current_peak(current_peak), .voltage_peak(voltage_peak),
    .write_settle_busy(write_settle_busy)
  );

  emcr_core_model core (
    .core_clk(core_clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .write_settle_busy(write_settle_busy), .hang(hang)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] msk(input logic [6:0] o);
    case (o)
      7'h0e, 7'h0f, 7'h10, 7'h13, 7'h1b: msk = 24'h0000ff;
      7'h24, 7'h25, 7'h26: msk = 24'h0000ff;
      7'h11, 7'h1c, 7'h1d, 7'h1e, 7'h1f: msk = 24'h000fff;
      7'h22, 7'h23: msk = 24'h000fff;
      7'h17, 7'h18, 7'h19, 7'h1a: msk = 24'hffffff;
      default: msk = 24'h00ffff;
    endcase
  endfunction

  function automatic logic [23:0] rst_val(input logic [6:0] o);
    case (o)
      7'h10: rst_val = 24'h000040;
      7'h11: rst_val = 24'h000fff;
      7'h12, 7'h15, 7'h16: rst_val = 24'h00ffff;
      7'h13: rst_val = 24'h0000ff;
      7'h28: rst_val = 24'h00003f;
      default: rst_val = 24'h000000;
    endcase
  endfunction

  task automatic test_reset_values();
    logic [23:0] v;
    for (int o = 'h0e; o <= 'h28; o++) begin
      core.reg_read(7'(o), v);
      chk(v, rst_val(7'(o)));
    end
  endtask

  // Pattern has nonzero bits above every field, so width and one-byte zeroing show
  task automatic test_readback();
    logic [23:0] v;
    logic [23:0] d;
    logic [7:0]  b;
    for (int o = 'h0e; o <= 'h28; o++) begin
      if (o < 'h17 || o > 'h1a) begin
        d = 24'hf5c396 ^ {17'h00000, 7'(o)};
        core.reg_write(7'(o), d, 1'b1);
        core.reg_read(7'(o), v);
        chk(v, d & msk(7'(o)));
      end
    end
    chk({8'h00, cfg.pulse_out_one_denominator}, 24'h00c3be);
    core.reg_write(OFS_I_PEAK, 24'h777777, 1'b1);
    core.reg_read(OFS_I_PEAK, v);
    chk(v, 24'h000000);
    core.reg_write(7'h7f, 24'h123456, 1'b1);
    core.reg_read(7'h7f, v);
    chk(v, 24'h000000);
    core.sfr_read(SFR_POINTER, b);
    chk({16'h0000, b}, 24'h00007f);
  endtask

  task automatic test_settle();
    core.reg_write(OFS_SAG_LVL, 24'h000155, 1'b0);
    chk({8'h00, cfg.sag_threshold}, 24'h000155);
    chk({23'h000000, write_settle_busy}, 24'h000001);
    repeat (int'(SETTLE_CYC) - 1) @(posedge core_clk);
    #1;
    chk({23'h000000, write_settle_busy}, 24'h000001);
    @(posedge core_clk);
    #1;
    chk({23'h000000, write_settle_busy}, 24'h000000);
    core.wait_settle();
  endtask

  task automatic test_peaks();
    logic [23:0] v;
    logic [23:0] e;
    logic [6:0]  o;
    @(posedge core_clk);
    #1;
    cur_sample_valid = 1'b1;
    volt_sample_valid = 1'b1;
    cur_sample = 24'h123456;
    volt_sample = 24'h0abcde;
    @(posedge core_clk);
    #1;
    cur_sample = 24'h000100;
    volt_sample = 24'h000200;
    @(posedge core_clk);
    #1;
    cur_sample_valid = 1'b0;
    volt_sample_valid = 1'b0;
    cur_sample = 24'hedcba9;
    volt_sample = 24'hf54321;
    chk(current_peak, 24'h123456);
    chk(voltage_peak, 24'h0abcde);
    for (int k = 0; k < 2; k++) begin
      o = (k == 0) ? OFS_I_PEAK : OFS_V_PEAK;
      e = (k == 0) ? 24'h123456 : 24'h0abcde;
      core.reg_read(o, v);
      chk(v, e);
      core.reg_read(o, v);
      chk(v, e);
      core.reg_read(o + 7'h01, v);
      chk(v, e);
      core.reg_read(o, v);
      chk(v, 24'h000000);
      // A sample landing on the clearing edge must survive the clear
      cur_sample = 24'h000005;
      volt_sample = 24'h000005;
      fork
        core.reg_read(o + 7'h01, v);
        begin
          @(posedge core_clk);
          #1;
          cur_sample_valid = (k == 0);
          volt_sample_valid = (k == 1);
          @(posedge core_clk);
          #1;
          cur_sample_valid = 1'b0;
          volt_sample_valid = 1'b0;
        end
      join
      chk(v, 24'h000000);
      core.reg_read(o, v);
      chk(v, 24'h000005);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hang) begin
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    total_checks = 0;
    nrst = 1'b0;
    cur_sample_valid = 1'b0;
    volt_sample_valid = 1'b0;
    cur_sample = 24'h000000;
    volt_sample = 24'h000000;
    repeat (16) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    test_reset_values();
    test_readback();
    test_settle();
    test_peaks();
    tally_and_finish();
  end
endmodule

`default_nettype wire
